// ---- verilog/conv_ctrl_pkg.sv ----
// Purpose: shared constants and carriers of the converter sequencer block
// Assumes: apb register bus, converter clock equal to pclk
// Notes: offsets are byte addresses of 32-bit words
package conv_ctrl_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] RESULT_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] COUNT_OFFSET = 8'h0C;
    localparam logic [7:0] START_ADDR_OFFSET = 8'h10;
    // control register field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_SEQ_LSB = 2;
    localparam int CTRL_MSC_BIT = 4;
    localparam int CTRL_SHT_LSB = 5;
    localparam int CTRL_TWO_BLOCK_BIT = 7;
    localparam int CTRL_FORMAT_BIT = 8;
    localparam int CTRL_SRC_LSB = 9;
    localparam int CTRL_CHAN_LSB = 12;
    // status register field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FLAG_BIT = 1;
    localparam int STAT_BLOCK_ONE_BIT = 2;
    // reset values
    localparam logic [15:0] START_ADDR_RESET = 16'h0200;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    // timing in converter clock cycles, then the byte address step per word
    localparam logic [6:0] SAMPLE_CYCLES_0 = 7'd4;
    localparam logic [6:0] SAMPLE_CYCLES_1 = 7'd8;
    localparam logic [6:0] SAMPLE_CYCLES_2 = 7'd16;
    localparam logic [6:0] SAMPLE_CYCLES_3 = 7'd64;
    localparam logic [6:0] CONVERT_CYCLES = 7'd13;
    localparam logic [15:0] WORD_STEP = 16'h0002;

    typedef enum logic [1:0]
    {
        MODE_SINGLE = 2'b00,
        MODE_SEQUENCE = 2'b01,
        MODE_REPEAT_SINGLE = 2'b10,
        MODE_REPEAT_SEQUENCE = 2'b11
    } seq_mode_t;

    // towards the analog core
    typedef struct packed
    {
        logic sampling_signal;
        logic converting;
        logic [3:0] channel;
    } core_ctrl_t;

    // towards the on-chip memory bus
    typedef struct packed
    {
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } mem_req_t;
endpackage

// ---- verilog/conv_sequencer.sv ----
// Purpose: converter mode sequencer and result transfer controller
// Assumes: converter clock is pclk; trigger pins synchronous to pclk
// Notes: apb slave with zero wait states; cpu halt is one cycle per word
// Summary of operation
// - sequence select 00 single, 01 sequence, 10 repeat single, 11 repeat seq
// - single mode converts selected channel once into result register
// - software start retriggers single mode; other sources need enable toggle
// - sequence mode converts selected channel down to channel zero, then stops
// - repeat single keeps converting selected channel, updating result
// - repeat sequence runs down to zero, then waits for next trigger
// - multi-sample-convert: first edge starts, later conversions start alone
// - multi-sample-convert ignores edges until sequence ends or enable toggles
// - clearing enable in single mode aborts at once; result undefined
// - clearing enable in repeat single finishes current conversion, halts
// - clearing enable in sequence modes finishes through channel zero
// - mode zero with enable cleared stops any activity immediately
// - transfer controller active with nonzero count; each result loads one
// - each transfer is one bus cycle with the cpu held halted
// - one-block layout: n words from start address to start plus 2n-2
// - hidden pointer steps by two, hidden counter counts down per word
// - one-block stops at zero until start or count rewritten; flag on block end
// - two-block layout: second block from start plus 2n to plus 4n-2
// - first block full sets flag and block-one, reloads counter with n
// - second block full sets flag and clears block-one indicator
// - rising edge on selected trigger source starts a conversion
// - sampling signal high 4, 8, 16 or 64 cycles after synchronizing
// - sampling falling edge starts a 13 cycle conversion
// - no new run starts without enable, a sequence may finish; most fields writable only while disabled
`timescale 1ns/1ps
module conv_sequencer
    import conv_ctrl_pkg::*;
(
    input wire logic pclk, // bus and converter clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [2:0] timer_trigger, // timer output trigger sources
    input wire logic [9:0] core_result, // core result, valid at convert end
    output conv_ctrl_pkg::core_ctrl_t core_ctrl, // sampling and channel
    output conv_ctrl_pkg::mem_req_t mem_req, // one-cycle memory write
    output logic cpu_halt // holds the cpu during a transfer
);
    import conv_ctrl_pkg::*;

    typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} conv_state_t;

    function automatic logic [6:0] sample_len(input logic [1:0] sel);
        case (sel)
            2'd0: sample_len = SAMPLE_CYCLES_0;
            2'd1: sample_len = SAMPLE_CYCLES_1;
            2'd2: sample_len = SAMPLE_CYCLES_2;
            default: sample_len = SAMPLE_CYCLES_3;
        endcase
    endfunction

    // control fields
    logic conversion_enable;
    logic software_start_bit;
    seq_mode_t conversion_sequence_select;
    logic multi_sample_convert;
    logic [1:0] sample_time_select;
    logic two_block_select;
    logic twos_format;
    logic [1:0] trigger_source;
    logic [3:0] input_channel_select;
    logic [15:0] conversion_result_register;
    logic converter_interrupt_flag;
    logic block_one_indicator;
    logic [7:0] transfer_count_register;
    logic [15:0] transfer_start_address;

    // sequencer state
    conv_state_t state;
    logic [6:0] cycle_count;
    logic [3:0] cur_channel;
    logic session; // run of any mode under way, held between channels
    logic msc_lock;
    logic armed;
    logic trig_prev;
    logic enable_prev;
    logic result_load;

    // transfer controller state
    logic [15:0] xfer_ptr;
    logic [7:0] xfer_cnt;
    logic xfer_live;
    logic second_block;

    logic wr_en;
    logic ctrl_wr;
    logic flag_clr;
    logic trig_level;
    logic trig_rise;
    logic abort;
    logic start_ok;
    logic conv_done;
    logic last_in_seq;
    logic seq_mode;
    logic xfer_fire;
    logic converter_busy_flag;
    logic [15:0] formatted;

    assign wr_en = psel && penable && pwrite;
    assign ctrl_wr = wr_en && paddr == CTRL_OFFSET;
    assign flag_clr = wr_en && paddr == STATUS_OFFSET
        && pwdata[STAT_FLAG_BIT];
    assign pready = 1'b1;

    // register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conversion_enable <= 1'b0;
            conversion_sequence_select <= MODE_SINGLE;
            multi_sample_convert <= 1'b0;
            sample_time_select <= 2'b00;
            two_block_select <= 1'b0;
            twos_format <= 1'b0;
            trigger_source <= 2'b00;
            input_channel_select <= 4'h0;
        end
        else if (ctrl_wr)
        begin
            conversion_enable <= pwdata[CTRL_ENABLE_BIT];
            // fields frozen while enabled; a write that clears enable may
            // change them in the same access so that a stop works
            if (!conversion_enable || !pwdata[CTRL_ENABLE_BIT])
            begin
                conversion_sequence_select <= seq_mode_t'(
                    pwdata[CTRL_SEQ_LSB +: 2]);
                multi_sample_convert <= pwdata[CTRL_MSC_BIT];
                sample_time_select <= pwdata[CTRL_SHT_LSB +: 2];
                two_block_select <= pwdata[CTRL_TWO_BLOCK_BIT];
                twos_format <= pwdata[CTRL_FORMAT_BIT];
                trigger_source <= pwdata[CTRL_SRC_LSB +: 2];
                input_channel_select <= pwdata[CTRL_CHAN_LSB +: 4];
            end
        end
    end

    // start bit reads back as zero; it acts for one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            software_start_bit <= 1'b0;
        else
            software_start_bit <= ctrl_wr && pwdata[CTRL_START_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            transfer_count_register <= COUNT_RESET;
            transfer_start_address <= START_ADDR_RESET;
        end
        else if (wr_en)
        begin
            if (paddr == COUNT_OFFSET)
                transfer_count_register <= pwdata[7:0];
            if (paddr == START_ADDR_OFFSET)
                transfer_start_address <= pwdata[15:0];
        end
    end

    // trigger selection and edge detect; the registered copy is the sync
    assign trig_level = (trigger_source == 2'b00) ? software_start_bit
        : timer_trigger[trigger_source - 2'd1];
    assign trig_rise = trig_level && !trig_prev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_prev <= 1'b0;
            enable_prev <= 1'b0;
        end
        else
        begin
            trig_prev <= trig_level;
            enable_prev <= conversion_enable;
        end
    end

    assign seq_mode = conversion_sequence_select[0];
    // single mode aborts on enable low; mode zero plus disable stops all
    assign abort = !conversion_enable
        && conversion_sequence_select == MODE_SINGLE;
    // a sequence already under way may finish its channels after disable
    assign start_ok = trig_rise && armed && !msc_lock
        && (conversion_enable || (session && seq_mode));
    assign conv_done = state == CONVERT && cycle_count == 7'd1;
    assign last_in_seq = !seq_mode || cur_channel == 4'h0;
    assign converter_busy_flag = state != IDLE || session;

    // conversion state machine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= IDLE;
            cycle_count <= 7'd0;
            cur_channel <= 4'h0;
            session <= 1'b0;
        end
        else if (abort)
        begin
            state <= IDLE;
            cycle_count <= 7'd0;
            session <= 1'b0;
        end
        else
        begin
            case (state)
                IDLE:
                begin
                    if (start_ok)
                    begin
                        state <= SAMPLE;
                        cycle_count <= sample_len(sample_time_select);
                        if (!session)
                            cur_channel <= input_channel_select;
                        session <= 1'b1;
                    end
                end
                SAMPLE:
                begin
                    cycle_count <= cycle_count - 7'd1;
                    if (cycle_count == 7'd1)
                    begin
                        state <= CONVERT;
                        cycle_count <= CONVERT_CYCLES;
                    end
                end
                CONVERT:
                begin
                    cycle_count <= cycle_count - 7'd1;
                    if (conv_done)
                    begin
                        case (conversion_sequence_select)
                            MODE_SINGLE:
                                session <= 1'b0;
                            MODE_SEQUENCE:
                            begin
                                if (last_in_seq)
                                    session <= 1'b0;
                                else
                                    cur_channel <= cur_channel - 4'h1;
                            end
                            MODE_REPEAT_SINGLE:
                                session <= conversion_enable;
                            default:
                            begin
                                if (last_in_seq)
                                begin
                                    cur_channel <= input_channel_select;
                                    session <= conversion_enable;
                                end
                                else
                                    cur_channel <= cur_channel - 4'h1;
                            end
                        endcase
                        // automatic restart skips the trigger wait
                        if (multi_sample_convert && conversion_enable
                            && conversion_sequence_select != MODE_SINGLE
                            && !(conversion_sequence_select == MODE_SEQUENCE
                            && last_in_seq))
                        begin
                            state <= SAMPLE;
                            cycle_count <= sample_len(sample_time_select);
                        end
                        else if (seq_mode && !last_in_seq
                            && multi_sample_convert)
                        begin
                            // disabled mid-sequence: keep running to zero
                            state <= SAMPLE;
                            cycle_count <= sample_len(sample_time_select);
                        end
                        else
                            state <= IDLE;
                    end
                end
                default:
                    state <= IDLE;
            endcase
        end
    end

    // edge lock for multi-sample-convert runs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            msc_lock <= 1'b0;
        else if (abort || (enable_prev && !conversion_enable))
            msc_lock <= 1'b0;
        else if (conv_done && conversion_sequence_select == MODE_SEQUENCE
            && last_in_seq)
            msc_lock <= 1'b0;
        else if (start_ok && multi_sample_convert
            && conversion_sequence_select != MODE_SINGLE)
            msc_lock <= 1'b1;
    end

    // timer-started single runs need enable to be set again
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            armed <= 1'b1;
        else if (conversion_enable && !enable_prev)
            armed <= 1'b1;
        else if (conv_done && trigger_source != 2'b00 && last_in_seq
            && !conversion_sequence_select[1])
            armed <= 1'b0;
    end

    // straight binary keeps upper bits zero; otherwise bit 9 inverted and sign extended
    assign formatted = twos_format
        ? {{7{~core_result[9]}}, core_result[8:0]}
        : {6'h00, core_result};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conversion_result_register <= 16'h0000;
            result_load <= 1'b0;
        end
        else
        begin
            result_load <= conv_done && !abort;
            if (conv_done && !abort)
                conversion_result_register <= formatted;
        end
    end

    // transfer controller
    assign xfer_fire = result_load && transfer_count_register != 8'h00
        && xfer_live && xfer_cnt != 8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xfer_ptr <= START_ADDR_RESET;
            xfer_cnt <= COUNT_RESET;
            xfer_live <= 1'b0;
            second_block <= 1'b0;
        end
        else if (wr_en && (paddr == START_ADDR_OFFSET
            || paddr == COUNT_OFFSET))
        begin
            // rewriting the setup restarts at block one
            xfer_ptr <= (paddr == START_ADDR_OFFSET) ? pwdata[15:0]
                : transfer_start_address;
            xfer_cnt <= (paddr == COUNT_OFFSET) ? pwdata[7:0]
                : transfer_count_register;
            xfer_live <= 1'b1;
            second_block <= 1'b0;
        end
        else if (xfer_fire)
        begin
            xfer_ptr <= xfer_ptr + WORD_STEP;
            if (xfer_cnt == 8'h01)
            begin
                if (two_block_select && !second_block)
                begin
                    xfer_cnt <= transfer_count_register;
                    second_block <= 1'b1;
                end
                else
                begin
                    xfer_cnt <= 8'h00;
                    xfer_live <= 1'b0;
                end
            end
            else
                xfer_cnt <= xfer_cnt - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_req <= '0;
            cpu_halt <= 1'b0;
        end
        else
        begin
            mem_req.write <= xfer_fire;
            cpu_halt <= xfer_fire;
            if (xfer_fire)
            begin
                mem_req.addr <= xfer_ptr;
                mem_req.data <= conversion_result_register;
            end
        end
    end

    // flags: a hardware set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_interrupt_flag <= 1'b0;
            block_one_indicator <= 1'b0;
        end
        else
        begin
            if ((xfer_fire && xfer_cnt == 8'h01)
                || (result_load && transfer_count_register == 8'h00))
                converter_interrupt_flag <= 1'b1;
            else if (flag_clr)
                converter_interrupt_flag <= 1'b0;
            if (xfer_fire && xfer_cnt == 8'h01 && two_block_select)
                block_one_indicator <= !second_block;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_ctrl <= '0;
        else
        begin
            core_ctrl.sampling_signal <= state == SAMPLE;
            core_ctrl.converting <= state == CONVERT;
            core_ctrl.channel <= cur_channel;
        end
    end

    // read mux; unmapped addresses answer with an error and zero data
    always_comb
    begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == CTRL_OFFSET)
        begin
            prdata[CTRL_ENABLE_BIT] = conversion_enable;
            prdata[CTRL_SEQ_LSB +: 2] = conversion_sequence_select;
            prdata[CTRL_MSC_BIT] = multi_sample_convert;
            prdata[CTRL_SHT_LSB +: 2] = sample_time_select;
            prdata[CTRL_TWO_BLOCK_BIT] = two_block_select;
            prdata[CTRL_FORMAT_BIT] = twos_format;
            prdata[CTRL_SRC_LSB +: 2] = trigger_source;
            prdata[CTRL_CHAN_LSB +: 4] = input_channel_select;
        end
        else if (paddr == RESULT_OFFSET)
            prdata[15:0] = conversion_result_register;
        else if (paddr == STATUS_OFFSET)
        begin
            prdata[STAT_BUSY_BIT] = converter_busy_flag;
            prdata[STAT_FLAG_BIT] = converter_interrupt_flag;
            prdata[STAT_BLOCK_ONE_BIT] = block_one_indicator;
        end
        else if (paddr == COUNT_OFFSET)
            prdata[7:0] = transfer_count_register;
        else if (paddr == START_ADDR_OFFSET)
            prdata[15:0] = transfer_start_address;
        else
            pslverr = psel && penable;
    end
endmodule

// ---- verif/mem_model.sv ----
// Purpose: on-chip memory and halted cpu behind the transfer port
// Assumes: one word taken per write pulse
// Notes: a write without halt counts as a bus clash
`timescale 1ns/1ps
module mem_model
    import conv_ctrl_pkg::*;
(
    input wire logic pclk, // memory clock
    input conv_ctrl_pkg::mem_req_t mem_req, // write port
    input wire logic cpu_halt // cpu held off
);
    logic [15:0] mem [0:255];
    int n_wr = 0;
    int n_clash = 0;
    always @(posedge pclk)
    begin
        if (mem_req.write)
        begin
            mem[mem_req.addr[8:1]] <= mem_req.data;
            n_wr <= n_wr + 1;
            if (!cpu_halt)
                n_clash <= n_clash + 1;
        end
    end
endmodule

// ---- verif/conv_sequencer_assertions.sv ----
// Purpose: port checks of the converter sequencer
// Assumes: one clock, reset low asynchronous
// Notes: bound into every sequencer instance
`timescale 1ns/1ps
module conv_sequencer_chk
    import conv_ctrl_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // direction
    input wire logic [7:0] paddr, // address
    input wire logic [31:0] pwdata, // wdata
    input wire logic [31:0] prdata, // rdata
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [2:0] timer_trigger, // timers
    input wire logic [9:0] core_result, // result
    input conv_ctrl_pkg::core_ctrl_t core_ctrl, // core side
    input conv_ctrl_pkg::mem_req_t mem_req, // memory side
    input wire logic cpu_halt // halt
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [6:0] conv_cnt;
    logic stop_hold; // a single-mode stop may cut a phase short
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conv_cnt <= 7'h00;
        else if (core_ctrl.converting)
            conv_cnt <= conv_cnt + 7'h01;
        else
            conv_cnt <= 7'h00;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stop_hold <= 1'b0;
        else if (psel && penable && pwrite && paddr == CTRL_OFFSET)
            stop_hold <= !pwdata[CTRL_ENABLE_BIT]
                && pwdata[CTRL_SEQ_LSB +: 2] == 2'b00;
    end
    sequence conv_end;
        $fell(core_ctrl.converting);
    endsequence
    conv_len_a: assert property (
        disable iff (!presetn || stop_hold)
        conv_end |-> conv_cnt == CONVERT_CYCLES)
        else $error("conversion length wrong");
    conv_max_a: assert property (conv_cnt <= CONVERT_CYCLES)
        else $error("conversion too long");
    samp_min_a: assert property (
        disable iff (!presetn || stop_hold)
        $rose(core_ctrl.sampling_signal)
        |-> core_ctrl.sampling_signal [*4]) else $error("sample too short");
    samp_conv_a: assert property (
        disable iff (!presetn || stop_hold)
        $fell(core_ctrl.sampling_signal)
        |-> ##[0:1] $rose(core_ctrl.converting)) else $error("no convert");
    phase_excl_a: assert property (!(core_ctrl.sampling_signal
        && core_ctrl.converting)) else $error("sample and convert overlap");
    chan_hold_a: assert property ($rose(core_ctrl.converting)
        |-> $stable(core_ctrl.channel) [*8]) else $error("channel moved");
    halt_pair_a: assert property (mem_req.write == cpu_halt)
        else $error("halt not with write");
    halt_once_a: assert property (cpu_halt |=> !cpu_halt)
        else $error("halt longer than one cycle");
    word_even_a: assert property (mem_req.write |-> !mem_req.addr[0])
        else $error("odd word address");
endmodule
bind conv_sequencer conv_sequencer_chk conv_sequencer_chk_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .timer_trigger, .core_result, .core_ctrl, .mem_req, .cpu_halt);

// ---- verif/tb_conv_sequencer.sv ----
// Purpose: register level tests of the converter sequencer
// Assumes: zero wait apb slave; core answers each conversion
// Notes: only the first timer source is exercised besides software start
`timescale 1ns/1ps
module tb_conv_sequencer;
    import conv_ctrl_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] core_result = 10'h000;
    logic [2:0] timer_trigger = 3'h0;
    core_ctrl_t core_ctrl;
    mem_req_t mem_req;
    logic cpu_halt;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int checks_done = 0;
    always #5 pclk = ~pclk;
    conv_sequencer conv_sequencer_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .timer_trigger, .core_result, .core_ctrl, .mem_req, .cpu_halt);
    mem_model mem_model_inst (.pclk, .mem_req, .cpu_halt);
    // channel in the upper bits makes every word traceable
    always @(posedge pclk)
        core_result <= {core_ctrl.channel, 6'h15};
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            check(pready, 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wait_wr(input int k);
        int n;
        n = 0;
        while (mem_model_inst.n_wr < k && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        check(mem_model_inst.n_wr, k);
    endtask
    task poll(input logic [31:0] mask, input logic [31:0] val);
        int n;
        n = 0;
        apb(0, STATUS_OFFSET, 0);
        while ((rd & mask) !== val && n < 300)
        begin
            apb(0, STATUS_OFFSET, 0);
            n++;
        end
        check(rd & mask, val);
    endtask
    // one-cycle timer pulse, then time for a whole conversion
    task pulse_timer;
        timer_trigger <= 3'h1;
        @(posedge pclk);
        timer_trigger <= 3'h0;
        repeat (30) @(posedge pclk);
    endtask
    task wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, START_ADDR_OFFSET, 0);
        check(rd, 32'h0200);
        apb(0, 8'h40, 0);
        check(err, 1);
        apb(1, COUNT_OFFSET, 2);
        apb(1, START_ADDR_OFFSET, 32'h0300);
        apb(1, CTRL_OFFSET, 32'h1017);
        apb(0, STATUS_OFFSET, 0);
        check(rd[0], 1);
        wait_wr(2);
        check(mem_model_inst.mem[8'h80], 16'h0055);
        check(mem_model_inst.mem[8'h81], 16'h0015);
        poll(32'h7, 32'h2);
        apb(1, CTRL_OFFSET, 32'h1017);
        poll(32'h1, 32'h1);
        poll(32'h1, 32'h0);
        check(mem_model_inst.n_wr, 2);
        apb(1, STATUS_OFFSET, 32'h2);
        apb(1, CTRL_OFFSET, 0);
        apb(1, COUNT_OFFSET, 1);
        apb(1, START_ADDR_OFFSET, 32'h0310);
        apb(1, CTRL_OFFSET, 32'h1097);
        wait_wr(3);
        poll(32'h6, 32'h6);
        wait_wr(4);
        check(mem_model_inst.mem[8'h88], 16'h0055);
        check(mem_model_inst.mem[8'h89], 16'h0015);
        poll(32'h7, 32'h2);
        apb(1, CTRL_OFFSET, 0);
        apb(1, COUNT_OFFSET, 0);
        apb(1, STATUS_OFFSET, 32'h2);
        apb(1, CTRL_OFFSET, 32'h3003);
        poll(32'h3, 32'h2);
        apb(0, RESULT_OFFSET, 0);
        check(rd, 32'h00D5);
        check(mem_model_inst.n_wr, 4);
        apb(1, CTRL_OFFSET, 0);
        apb(1, STATUS_OFFSET, 32'h2);
        apb(1, CTRL_OFFSET, 32'h201B);
        poll(32'h2, 32'h2);
        apb(1, STATUS_OFFSET, 32'h2);
        poll(32'h2, 32'h2);
        apb(1, STATUS_OFFSET, 32'h2);
        apb(1, CTRL_OFFSET, 32'h2008);
        poll(32'h3, 32'h2);
        apb(0, RESULT_OFFSET, 0);
        check(rd, 32'h0095);
        apb(1, CTRL_OFFSET, 32'h2003);
        apb(1, CTRL_OFFSET, 0);
        apb(0, STATUS_OFFSET, 0);
        check(rd[0], 0);
        apb(1, STATUS_OFFSET, 32'h2);
        apb(1, CTRL_OFFSET, 32'h1201);
        pulse_timer;
        poll(32'h3, 32'h2);
        apb(1, STATUS_OFFSET, 32'h2);
        pulse_timer;
        poll(32'h3, 32'h0);
        apb(1, CTRL_OFFSET, 32'h0200);
        apb(1, CTRL_OFFSET, 32'h0205);
        pulse_timer;
        poll(32'h3, 32'h2);
        apb(1, STATUS_OFFSET, 32'h2);
        pulse_timer;
        poll(32'h3, 32'h0);
        check(mem_model_inst.n_clash, 0);
        wrap_up;
    end
    initial
    begin
        #200000;
        n_fail++;
        wrap_up;
    end
endmodule
